// File: rtl/dio_intc.v
// Top of the dual output interrupt controller with its APB register file.
// Assumes on-chip sources are on pclk and off-chip lines and pins are async.
`include "dio_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module dio_intc (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [43:0] internal_sources,
  input  wire [3:0]  ext_int_lines,
  input  wire [15:0] expanded_general_pins,
  output reg         interrupt_request,
  output reg         fast_interrupt_request,
  output reg         event_irq
);

  ////////////////////////////////////////////////////////////////////////////

  function is_slot_addr;
    input [11:0] a;
    begin
      is_slot_addr = (a >= `DIO_OFF_SLOT_BASE) && (a <= `DIO_OFF_SLOT_LAST) &&
                     (a[1:0] == 2'h0);
    end
  endfunction

  // A write strobe aimed at one offset; the two clear registers use it.
  function wr_hit;
    input        wr;
    input [11:0] a;
    input [11:0] off;
    begin
      wr_hit = wr && (a == off);
    end
  endfunction

  reg [63:0] enable_reg;
  reg [63:0] route_reg;
  reg [63:0] polarity_reg;
  reg [31:0] pin_mode_reg;
  reg [15:0] pin_en_reg;
  reg [5:0]  thr_reg;
  reg [1:0]  fmask_reg;
  reg [6:0]  slot_reg [0:31];
  reg [6:0]  fslot_reg [0:1];
  reg [2:0]  ev_stat_reg;
  reg [2:0]  ev_en_reg;
  reg [2:0]  ev_stat_next;
  reg [31:0] rdata_next;
  reg        err_next;

  wire        wr_en = psel & penable & pwrite & pready;
  wire        setup_phase = psel & ~penable;
  wire [4:0]  slot_idx = paddr[6:2];
  wire [15:0] edge_clr = wr_hit(wr_en, paddr, `DIO_OFF_EDGE_CLR) ? pwdata[15:0] : 16'h0000;
  wire [2:0]  ev_clr = wr_hit(wr_en, paddr, `DIO_OFF_EV_CLR) ? pwdata[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Source collection: on-chip sources, dedicated lines, expanded pins.

  wire [3:0]  line_sync;
  wire [15:0] pin_sync;
  wire [15:0] pin_active;
  wire        edge_seen;

  dio_sync #(
    .WIDTH (20)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({expanded_general_pins, ext_int_lines}),
    .sync_out ({pin_sync, line_sync})
  );

  dio_pin_detect #(
    .PINS (16)
  ) u_pins (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_level  (pin_sync),
    .pin_mode   (pin_mode_reg),
    .pin_enable (pin_en_reg),
    .edge_clear (edge_clr),
    .pin_active (pin_active),
    .edge_seen  (edge_seen)
  );

  // On-chip sources share pclk, so they reach the polarity logic unsynchronised.
  wire [43:0] chip_active = internal_sources ^ polarity_reg[43:0];            // see R4
  // The dedicated lines get no edge option; they are level only.
  wire [3:0]  line_active = line_sync ^ polarity_reg[47:44];                  // see R6
  wire [63:0] raw_active = {pin_active, line_active, chip_active};           // see R1
  wire [63:0] pending = raw_active & enable_reg;
  wire [63:0] norm_pend = pending & ~route_reg;                              // see R1
  wire [63:0] fast_pend = pending & route_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Priority mask and vectoring.

  reg [63:0] nblock;
  reg [63:0] fblock;
  reg        nvec_found;
  reg        nvec_slotted;
  reg [4:0]  nvec_slot;
  reg [5:0]  nvec_src;
  reg        fvec_found;
  reg        fvec_slotted;
  reg        fvec_level;
  reg [5:0]  fvec_src;
  integer    k;
  integer    km;
  integer    kn;
  integer    kf;

  // A slot at or above the threshold index is masked; unassigned sources
  // are never masked, so software must give them a slot to hide them.
  always @* begin
    nblock = 64'h0000000000000000;
    for (k = 0; k < `DIO_NUM_SLOTS; k = k + 1) begin
      if (slot_reg[k][`DIO_SLOT_VALID] && (k >= thr_reg)) begin               // see R8
        nblock[slot_reg[k][5:0]] = 1'b1;
      end
    end
  end

  always @* begin
    fblock = 64'h0000000000000000;
    for (km = 0; km < `DIO_NUM_FSLOTS; km = km + 1) begin
      if (fslot_reg[km][`DIO_SLOT_VALID] && fmask_reg[km]) begin            // see R8
        fblock[fslot_reg[km][5:0]] = 1'b1;
      end
    end
  end

  wire [63:0] norm_live = norm_pend & ~nblock;
  wire [63:0] fast_live = fast_pend & ~fblock;
  wire        norm_req = |norm_live;                                         // see R9
  wire        fast_req = |fast_live;                                         // see R9

  // Lowest slot wins; loops run downward so the last hit is the winner.
  always @* begin
    nvec_found = 1'b0;
    nvec_slotted = 1'b0;
    nvec_slot = 5'h00;
    nvec_src = 6'h00;
    for (kn = `DIO_NUM_SRC - 1; kn >= 0; kn = kn - 1) begin
      if (norm_live[kn]) begin
        nvec_found = 1'b1;
        nvec_src = kn[5:0];
      end
    end
    for (kn = `DIO_NUM_SLOTS - 1; kn >= 0; kn = kn - 1) begin
      if (slot_reg[kn][`DIO_SLOT_VALID] && norm_live[slot_reg[kn][5:0]]) begin // see R2
        nvec_slotted = 1'b1;
        nvec_slot = kn[4:0];
        nvec_src = slot_reg[kn][5:0];
      end
    end
  end

  always @* begin
    fvec_found = 1'b0;
    fvec_slotted = 1'b0;
    fvec_level = 1'b0;
    fvec_src = 6'h00;
    for (kf = `DIO_NUM_SRC - 1; kf >= 0; kf = kf - 1) begin
      if (fast_live[kf]) begin
        fvec_found = 1'b1;
        fvec_src = kf[5:0];
      end
    end
    for (kf = `DIO_NUM_FSLOTS - 1; kf >= 0; kf = kf - 1) begin
      if (fslot_reg[kf][`DIO_SLOT_VALID] && fast_live[fslot_reg[kf][5:0]]) begin // see R3
        fvec_slotted = 1'b1;
        fvec_level = kf[0];
        fvec_src = fslot_reg[kf][5:0];
      end
    end
  end

  // Vector word: [31] an unmasked routed source is pending, [30] the winner sits in a slot,
  // then the slot index (normal) or the level (fast), and the source number.
  wire [31:0] nvec_word;
  wire [31:0] fvec_word;

  assign nvec_word[`DIO_VEC_VALID]        = nvec_found;
  assign nvec_word[`DIO_VEC_SLOTTED]      = nvec_slotted;
  assign nvec_word[29:13]                 = 17'h00000;
  assign nvec_word[12:`DIO_VEC_SLOT_LSB]  = nvec_slot;
  assign nvec_word[7:6]                   = 2'h0;
  assign nvec_word[5:0]                   = nvec_src;

  assign fvec_word[`DIO_VEC_VALID]        = fvec_found;
  assign fvec_word[`DIO_VEC_SLOTTED]      = fvec_slotted;
  assign fvec_word[29:9]                  = 21'h000000;
  assign fvec_word[`DIO_VEC_SLOT_LSB]     = fvec_level;
  assign fvec_word[7:6]                   = 2'h0;
  assign fvec_word[5:0]                   = fvec_src;

  ////////////////////////////////////////////////////////////////////////////
  // Event status and request outputs.

  wire [2:0] ev_set;

  assign ev_set[`DIO_EV_NORM] = norm_req & ~interrupt_request;
  assign ev_set[`DIO_EV_FAST] = fast_req & ~fast_interrupt_request;
  assign ev_set[`DIO_EV_EDGE] = edge_seen;

  always @* begin
    ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request <= 1'b0;
      fast_interrupt_request <= 1'b0;
    end else begin
      interrupt_request <= norm_req;                                          // see R9
      fast_interrupt_request <= fast_req;                                     // see R9
    end
  end

  // The event line is built from the next status so it moves on the same edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_reg <= 3'h0;
      event_irq <= 1'b0;
    end else begin
      ev_stat_reg <= ev_stat_next;
      event_irq <= |(ev_stat_next & ev_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path: data is prepared in the setup cycle and shown in access.

  always @* begin
    rdata_next = 32'h00000000;
    err_next = 1'b0;
    if (is_slot_addr(paddr)) begin
      rdata_next = {25'h0000000, slot_reg[slot_idx]};
    end else begin
      case (paddr)
        `DIO_OFF_RAW_LO:    rdata_next = raw_active[31:0];
        `DIO_OFF_RAW_HI:    rdata_next = raw_active[63:32];
        `DIO_OFF_EN_LO:     rdata_next = enable_reg[31:0];
        `DIO_OFF_EN_HI:     rdata_next = enable_reg[63:32];
        `DIO_OFF_ROUTE_LO:  rdata_next = route_reg[31:0];
        `DIO_OFF_ROUTE_HI:  rdata_next = route_reg[63:32];
        `DIO_OFF_POL_LO:    rdata_next = polarity_reg[31:0];
        `DIO_OFF_POL_HI:    rdata_next = polarity_reg[63:32];
        `DIO_OFF_PIN_MODE:  rdata_next = pin_mode_reg;
        `DIO_OFF_PIN_EN:    rdata_next = {16'h0000, pin_en_reg};
        `DIO_OFF_EDGE_CLR:  rdata_next = 32'h00000000;
        `DIO_OFF_NVEC:      rdata_next = nvec_word;
        `DIO_OFF_PRIO_MASK: rdata_next = {22'h000000, fmask_reg, 2'h0, thr_reg};
        `DIO_OFF_PEND_LO:   rdata_next = pending[31:0];
        `DIO_OFF_PEND_HI:   rdata_next = pending[63:32];
        `DIO_OFF_FSLOT0:    rdata_next = {25'h0000000, fslot_reg[0]};
        `DIO_OFF_FSLOT1:    rdata_next = {25'h0000000, fslot_reg[1]};
        `DIO_OFF_FVEC:      rdata_next = fvec_word;
        `DIO_OFF_EV_STAT:   rdata_next = {29'h00000000, ev_stat_reg};
        `DIO_OFF_EV_CLR:    rdata_next = 32'h00000000;
        `DIO_OFF_EV_EN:     rdata_next = {29'h00000000, ev_en_reg};
        default:            err_next = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // No wait states: every access is answered in the cycle after its setup.
      pready <= setup_phase;
      pslverr <= setup_phase & err_next;
      prdata <= (setup_phase & ~pwrite & ~err_next) ? rdata_next : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB write path: a write lands at the access edge with pready high.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 64'h0000000000000000;
      route_reg <= 64'h0000000000000000;
      polarity_reg <= 64'h0000000000000000;
      pin_mode_reg <= 32'h00000000;
      pin_en_reg <= 16'h0000;
      thr_reg <= `DIO_RST_THR;
      fmask_reg <= 2'h0;
      ev_en_reg <= 3'h0;
      fslot_reg[0] <= 7'h00;
      fslot_reg[1] <= 7'h00;
    end else if (wr_en) begin
      case (paddr)
        `DIO_OFF_EN_LO:     enable_reg[31:0] <= pwdata;
        `DIO_OFF_EN_HI:     enable_reg[63:32] <= pwdata;
        `DIO_OFF_ROUTE_LO:  route_reg[31:0] <= pwdata;                        // see R1
        `DIO_OFF_ROUTE_HI:  route_reg[63:32] <= pwdata;                       // see R1
        `DIO_OFF_POL_LO:    polarity_reg[31:0] <= pwdata;                     // see R4
        `DIO_OFF_POL_HI:    polarity_reg[63:32] <= pwdata;                    // see R4
        `DIO_OFF_PIN_MODE:  pin_mode_reg <= pwdata;                           // see R5
        `DIO_OFF_PIN_EN:    pin_en_reg <= pwdata[15:0];                       // see R7
        `DIO_OFF_PRIO_MASK: begin
          thr_reg <= pwdata[`DIO_THR_MSB:0];                                  // see R8
          fmask_reg <= pwdata[`DIO_FMASK_LSB+1:`DIO_FMASK_LSB];               // see R8
        end
        `DIO_OFF_FSLOT0:    fslot_reg[0] <= pwdata[6:0];                      // see R3
        `DIO_OFF_FSLOT1:    fslot_reg[1] <= pwdata[6:0];                      // see R3
        `DIO_OFF_EV_EN:     ev_en_reg <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Slot storage is kept apart so the whole array resets in one loop.
  genvar s;
  generate
    for (s = 0; s < `DIO_NUM_SLOTS; s = s + 1) begin : slot
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_reg[s] <= 7'h00;
        end else if (wr_en && is_slot_addr(paddr) && slot_idx == s) begin
          slot_reg[s] <= pwdata[6:0];                                         // see R2
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: shared/dio_defines.vh
// Register map, field positions and reset values of the interrupt controller.
// Assumes a 32-bit APB slave with byte addresses taken from paddr[11:0].
// Notes on behaviour
// R1 - Sixty-four sources, each steered to the normal or the fast request.
// R2 - Thirty-two priority slots help software vector normal requests.
// R3 - Two priority levels help software vector fast requests.
// R4 - Each on-chip source is level sensitive, active high or active low.
// R5 - Each pin source is high level, low level, rising or falling edge.
// R6 - The four dedicated off-chip lines act as level sensitive sources.
// R7 - Each of the sixteen expanded pins may be enabled as an interrupt input.
// R8 - A software priority mask covers the normal and fast sources that are assigned to a slot.
// R9 - A request is high only while an unmasked routed source is active.
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH
`define DIO_NUM_SRC        64
`define DIO_NUM_INTERNAL   44
`define DIO_NUM_LINES      4
`define DIO_NUM_PINS       16
`define DIO_NUM_SLOTS      32
`define DIO_NUM_FSLOTS     2
`define DIO_OFF_RAW_LO     12'h000
`define DIO_OFF_RAW_HI     12'h004
`define DIO_OFF_EN_LO      12'h008
`define DIO_OFF_EN_HI      12'h00C
`define DIO_OFF_ROUTE_LO   12'h010
`define DIO_OFF_ROUTE_HI   12'h014
`define DIO_OFF_POL_LO     12'h018
`define DIO_OFF_POL_HI     12'h01C
`define DIO_OFF_PIN_MODE   12'h020
`define DIO_OFF_PIN_EN     12'h024
`define DIO_OFF_EDGE_CLR   12'h028
`define DIO_OFF_NVEC       12'h02C
`define DIO_OFF_PRIO_MASK  12'h030
`define DIO_OFF_PEND_LO    12'h034
`define DIO_OFF_PEND_HI    12'h038
`define DIO_OFF_FSLOT0     12'h040
`define DIO_OFF_FSLOT1     12'h044
`define DIO_OFF_FVEC       12'h048
`define DIO_OFF_EV_STAT    12'h050
`define DIO_OFF_EV_CLR     12'h054
`define DIO_OFF_EV_EN      12'h058
`define DIO_OFF_SLOT_BASE  12'h100
`define DIO_OFF_SLOT_LAST  12'h17C
`define DIO_SLOT_VALID     6
`define DIO_THR_MSB        5
`define DIO_FMASK_LSB      8
`define DIO_VEC_VALID      31
`define DIO_VEC_SLOTTED    30
`define DIO_VEC_SLOT_LSB   8
`define DIO_EV_NORM        0
`define DIO_EV_FAST        1
`define DIO_EV_EDGE        2
`define DIO_RST_THR        6'h20
`define DIO_MODE_HIGH      2'h0
`define DIO_MODE_LOW       2'h1
`define DIO_MODE_RISE      2'h2
`define DIO_MODE_FALL      2'h3
`endif

// File: rtl/dio_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module dio_sync #(
  parameter WIDTH = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: rtl/dio_pin_detect.v
// Per-pin sensitivity logic for the expanded general pins.
// Assumes the pin levels are already synchronised to pclk.
`include "dio_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module dio_pin_detect #(
  parameter PINS = 16
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire [PINS-1:0]   pin_level,
  input  wire [2*PINS-1:0] pin_mode,
  input  wire [PINS-1:0]   pin_enable,
  input  wire [PINS-1:0]   edge_clear,
  output wire [PINS-1:0]   pin_active,
  output wire              edge_seen
);
  reg  [PINS-1:0] prev_reg;
  reg  [PINS-1:0] latch_reg;
  wire [PINS-1:0] edge_hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= {PINS{1'b0}};
    end else begin
      prev_reg <= pin_level;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      wire [1:0] mode = pin_mode[2*g+1:2*g];
      // A disabled pin neither captures edges nor raises a request.
      assign edge_hit[g] = pin_enable[g] & (                                  // see R7
                           (mode == `DIO_MODE_RISE & pin_level[g] & ~prev_reg[g]) |
                           (mode == `DIO_MODE_FALL & ~pin_level[g] & prev_reg[g]));
      // A new edge in the clear cycle survives the clear.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          latch_reg[g] <= 1'b0;
        end else begin
          latch_reg[g] <= (latch_reg[g] & ~edge_clear[g]) | edge_hit[g];
        end
      end
      assign pin_active[g] = pin_enable[g] & (                                // see R5
                             (mode == `DIO_MODE_HIGH & pin_level[g]) |
                             (mode == `DIO_MODE_LOW & ~pin_level[g]) |
                             (mode[1] & latch_reg[g]));
    end
  endgenerate

  assign edge_seen = |edge_hit;
endmodule
`default_nettype wire

// File: testbench/dio_core_model.sv
// Model of the core's normal and fast request inputs.
// Assumes both requests are levels synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module dio_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       norm_req,
  input  wire logic       fast_req,
  output logic [7:0]      norm_seen,
  output logic [7:0]      fast_seen
);
  logic norm_reg;
  logic fast_reg;
  ////////////////////////////////////////////////////////////////
  // A core enters its handler once per rising level, so only rises count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      norm_reg <= 1'b0;
      fast_reg <= 1'b0;
      norm_seen <= 8'h00;
      fast_seen <= 8'h00;
    end else begin
      norm_reg <= norm_req;
      fast_reg <= fast_req;
      if (norm_req && !norm_reg) norm_seen <= norm_seen + 8'h01;
      if (fast_req && !fast_reg) fast_seen <= fast_seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/dio_intc_sva.sv
// Checker on the ports of the interrupt controller top.
// Assumes one clock domain and the APB master of the bench.
`timescale 1ns/1ns
`default_nettype none
module dio_intc_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [43:0] internal_sources,
  input wire logic [3:0]  ext_int_lines,
  input wire logic [15:0] expanded_general_pins,
  input wire logic        interrupt_request,
  input wire logic        fast_interrupt_request,
  input wire logic        event_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Six quiet cycles cover the four-edge path of a pin edge latch.
  sequence quiet;
    !(psel && pwrite) && $stable(internal_sources) && $stable(ext_int_lines)
      && $stable(expanded_general_pins);
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero");
  a_norm_req_hold: assert property (quiet [*6] |=> $stable(interrupt_request))
    else $error("normal request moved without cause");
  a_fast_req_hold: assert property (quiet [*6] |=> $stable(fast_interrupt_request))
    else $error("fast request moved without cause");
  a_event_irq_hold: assert property (quiet [*6] |=> $stable(event_irq))
    else $error("event line moved without cause");
  c_error: cover property (pready && pslverr);
  c_norm: cover property ($rose(interrupt_request));
  c_fast: cover property ($rose(fast_interrupt_request));
  c_event: cover property ($rose(event_irq));
endmodule
bind dio_intc dio_intc_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .internal_sources, .ext_int_lines,
  .expanded_general_pins, .interrupt_request, .fast_interrupt_request, .event_irq);
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the dual output interrupt controller.
// Assumes the controller, its checker and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rq;
  logic        pready;
  logic        pslverr;
  logic        re;
  logic        nreq;
  logic        freq;
  logic        ereq;
  logic [43:0] src = 44'h0;
  logic [3:0]  line = 4'h0;
  logic [15:0] pin = 16'h0;
  logic [7:0]  norm_seen;
  logic [7:0]  fast_seen;
  int          err_total = 0;
  int          total_checks = 0;
  always #5 pclk = ~pclk;
  dio_intc uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .internal_sources(src), .ext_int_lines(line),
    .expanded_general_pins(pin), .interrupt_request(nreq),
    .fast_interrupt_request(freq), .event_irq(ereq));
  dio_core_model core (.pclk, .presetn, .norm_req(nreq), .fast_req(freq),
    .norm_seen, .fast_seen);
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task xf(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for ready.
    do begin
      @(posedge pclk);
    end while (!pready);
    rq = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task final_report;
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    xf(0, 12'h030, 0);
    chk(rq, 32'h20);
    xf(0, 12'h200, 0);
    chk(re, 1);
    xf(1, 12'h008, 32'h8);
    @(posedge pclk);
    src[3] <= 1;
    w(3);
    chk(nreq, 1);
    chk(freq, 0);
    xf(1, 12'h018, 32'h8);
    w(3);
    chk(nreq, 0);
    xf(1, 12'h018, 0);
    xf(1, 12'h114, 32'h43);
    xf(0, 12'h02C, 0);
    chk(rq, 32'hC0000503);
    xf(1, 12'h030, 32'h5);
    w(3);
    chk(nreq, 0);
    xf(1, 12'h030, 32'h6);
    w(3);
    chk(nreq, 1);
    xf(1, 12'h030, 32'h20);
    xf(1, 12'h010, 32'h8);
    xf(1, 12'h044, 32'h43);
    w(3);
    chk(freq, 1);
    chk(nreq, 0);
    xf(0, 12'h048, 0);
    chk(rq, 32'hC0000103);
    xf(1, 12'h030, 32'h220);
    w(3);
    chk(freq, 0);
    xf(1, 12'h030, 32'h20);
    xf(1, 12'h010, 0);
    // Event path: enabled, cleared, then masked by its enable.
    xf(1, 12'h054, 32'h7);
    xf(1, 12'h058, 32'h1);
    @(posedge pclk);
    src[3] <= 0;
    w(3);
    src[3] <= 1;
    w(3);
    chk(ereq, 1);
    xf(0, 12'h050, 0);
    chk(rq & 32'h1, 1);
    xf(1, 12'h054, 32'h7);
    w(2);
    chk(ereq, 0);
    xf(1, 12'h058, 0);
    src[3] <= 0;
    w(3);
    src[3] <= 1;
    w(3);
    chk(ereq, 0);
    src[3] <= 0;
    xf(1, 12'h00C, 32'h42000);
    @(posedge pclk);
    line[1] <= 1;
    w(5);
    chk(nreq, 1);
    line[1] <= 0;
    w(5);
    chk(nreq, 0);
    xf(1, 12'h024, 32'h4);
    // Pin 2: start inactive, go active, then return; edges stay latched.
    for (int m = 0; m < 4; m++) begin
      xf(1, 12'h020, m << 4);
      @(posedge pclk);
      pin[2] <= m[0];
      w(6);
      xf(1, 12'h028, 32'h4);
      w(2);
      chk(nreq, 0);
      pin[2] <= !m[0];
      w(6);
      chk(nreq, 1);
      pin[2] <= m[0];
      w(6);
      chk(nreq, m[1]);
    end
    xf(1, 12'h020, 0);
    xf(1, 12'h024, 0);
    @(posedge pclk);
    pin[2] <= 1;
    w(6);
    chk(nreq, 0);
    chk(fast_seen != 8'h00, 1);
    chk(norm_seen != 8'h00, 1);
    xf(0, 12'h050, 0);
    chk(rq, 32'h5);
    final_report;
  end
endmodule
`default_nettype wire
